/* File: alarm_status_aggregator.sv */
// alarm status aggregator: status, mask and summary registers and the pin mux
// assumes register requests are single-cycle strobes, synchronous to ref_clk_in
`timescale 1ns/10ps

module alarm_status_aggregator #(
	parameter int LANES = alarm_pkg::LANES_DEFAULT
) (
	// clock and reset
	input  wire logic                             ref_clk_in,
	input  wire logic                             reset_in,
	input  wire logic                             soft_reset_in,
	// register access
	input  wire alarm_pkg::reg_req_s              reg_req_in,
	output logic [alarm_pkg::REG_DATA_W-1:0]      reg_rdata_out,
	// alarm sources
	input  wire alarm_pkg::alarm_src_s            alarm_src_in,
	input  wire logic [LANES-1:0]                 lane_active_in,
	input  wire logic [LANES-1:0]                 lane_fifo_error_in,
	// calibration status pin
	input  wire logic                             cal_status_sel_alarm_in,
	input  wire logic                             cal_status_other_in,
	output logic                                  calibration_status_pin_out,
	// per-lane error register clear
	output logic                                  per_lane_buffer_errors_clear_out
);

	import alarm_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]            alarm_source_flags;
	logic [7:0]            next_alarm_source_flags;
	logic [7:0]            alarm_source_disable;
	logic [7:0]            next_alarm_source_disable;
	logic                  summary_alarm;
	logic                  next_summary_alarm;
	logic [REG_DATA_W-1:0] rdata;
	logic [REG_DATA_W-1:0] next_rdata;
	logic                  cal_pin;
	logic                  next_cal_pin;
	logic                  lane_clear;
	logic                  next_lane_clear;
	logic                  link_enable_d;
	logic                  next_link_enable_d;

	logic [7:0]            set_vec;
	logic [7:0]            clear_vec;
	logic [LANES-1:0]      lane_hit;
	logic                  flags_write;
	logic                  disable_write;

	// ----------------------------------------------------------------
	// alarm sources
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign lane_hit[g] = lane_active_in[g] & lane_fifo_error_in[g];
		end
	endgenerate

	always_comb begin
		set_vec = 8'h00;
		set_vec[BIT_LANE_BUF] = |lane_hit;
		set_vec[BIT_SER_LOCK] = ~alarm_src_in.pll_locked;
		if (alarm_src_in.mode_64b66b) begin
			set_vec[BIT_LINK] = (alarm_src_in.serial_link_enable & ~link_enable_d)
				| (alarm_src_in.serial_link_enable & alarm_src_in.link_realign);
		end else begin
			set_vec[BIT_LINK] = alarm_src_in.serial_link_enable
				& ~alarm_src_in.data_phase_state;
		end
		set_vec[BIT_REALIGN] = alarm_src_in.sysref_realign;
		set_vec[BIT_DIVIDER] = alarm_src_in.divider_mismatch;
	end

	// ----------------------------------------------------------------
	// register file next values
	// ----------------------------------------------------------------
	assign flags_write   = reg_req_in.wr && (reg_req_in.addr == FLAGS_OFFSET);
	assign disable_write = reg_req_in.wr && (reg_req_in.addr == DISABLE_OFFSET);
	assign clear_vec     = flags_write ? (reg_req_in.wdata & FLAGS_STORED) : 8'h00;

	always_comb begin
		next_link_enable_d = alarm_src_in.serial_link_enable;
		if (soft_reset_in) begin
			next_alarm_source_flags   = FLAGS_RESET;
			next_alarm_source_disable = DISABLE_RESET;
			next_lane_clear           = 1'b0;
		end else begin
			next_alarm_source_flags = ((alarm_source_flags & ~clear_vec) | set_vec)
				& FLAGS_STORED;
			next_alarm_source_disable = disable_write ? reg_req_in.wdata
				: alarm_source_disable;
			next_lane_clear = flags_write & reg_req_in.wdata[BIT_LANE_BUF];
		end
		next_summary_alarm = |(next_alarm_source_flags & ~next_alarm_source_disable
			& ALARM_BITS);
		next_cal_pin = cal_status_sel_alarm_in ? next_summary_alarm : cal_status_other_in;
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = rdata;
		if (reg_req_in.rd) begin
			unique case (reg_req_in.addr)
				SUMMARY_OFFSET: next_rdata = {7'h00, summary_alarm};
				FLAGS_OFFSET:   next_rdata = alarm_source_flags;
				DISABLE_OFFSET: next_rdata = alarm_source_disable;
				default:        next_rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			alarm_source_flags   <= FLAGS_RESET;
			alarm_source_disable <= DISABLE_RESET;
			summary_alarm        <= SUMMARY_RESET[0];
			rdata                <= 8'h00;
			cal_pin              <= 1'b0;
			lane_clear           <= 1'b0;
			link_enable_d        <= 1'b0;
		end else begin
			alarm_source_flags   <= next_alarm_source_flags;
			alarm_source_disable <= next_alarm_source_disable;
			summary_alarm        <= next_summary_alarm;
			rdata                <= next_rdata;
			cal_pin              <= next_cal_pin;
			lane_clear           <= next_lane_clear;
			link_enable_d        <= next_link_enable_d;
		end
	end

	assign reg_rdata_out                    = rdata;
	assign calibration_status_pin_out       = cal_pin;
	assign per_lane_buffer_errors_clear_out = lane_clear;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	a_summary_matches: assert property (
		summary_alarm == |(alarm_source_flags & ~alarm_source_disable & ALARM_BITS))
		else $error("summary bit disagrees with unmasked flags");

	a_summary_read: assert property (
		reg_req_in.rd && reg_req_in.addr == SUMMARY_OFFSET
		|=> reg_rdata_out == {7'h00, $past(summary_alarm)})
		else $error("summary read returns wrong word");

	a_pin_routing: assert property (
		cal_status_sel_alarm_in && !soft_reset_in |=> calibration_status_pin_out == summary_alarm)
		else $error("pin does not follow summary bit");

	a_clear_works: assert property (
		flags_write && !soft_reset_in && reg_req_in.wdata[BIT_REALIGN] && !set_vec[BIT_REALIGN]
		|=> !alarm_source_flags[BIT_REALIGN])
		else $error("write one did not clear flag");

	a_lane_set: assert property (
		|(lane_active_in & lane_fifo_error_in) |=> alarm_source_flags[BIT_LANE_BUF])
		else $error("lane buffer error not recorded");

	a_lock_set: assert property (
		!alarm_src_in.pll_locked |=> alarm_source_flags[BIT_SER_LOCK])
		else $error("lock loss not recorded");

	a_link_8b: assert property (
		!alarm_src_in.mode_64b66b && alarm_src_in.serial_link_enable
		&& !alarm_src_in.data_phase_state |=> alarm_source_flags[BIT_LINK])
		else $error("link not running not recorded");

	a_link_start: assert property (
		alarm_src_in.mode_64b66b && $rose(alarm_src_in.serial_link_enable)
		|=> alarm_source_flags[BIT_LINK])
		else $error("64b66b link start not recorded");

	a_realign_set: assert property (
		alarm_src_in.sysref_realign |=> alarm_source_flags[BIT_REALIGN])
		else $error("clock realign not recorded");

	a_divider_set: assert property (
		alarm_src_in.divider_mismatch |=> alarm_source_flags[BIT_DIVIDER])
		else $error("divider mismatch not recorded");

	a_soft_reset: assert property (
		soft_reset_in |=> alarm_source_flags == FLAGS_RESET && alarm_source_disable == DISABLE_RESET)
		else $error("software reset did not restore values");

	a_flags_hold: assert property (
		!flags_write && !soft_reset_in |=> ($past(alarm_source_flags) & ~alarm_source_flags) == 8'h00)
		else $error("flag dropped without a clear");

	a_mask_keeps: assert property (
		alarm_source_disable[BIT_DIVIDER] && alarm_src_in.divider_mismatch && !disable_write
		|=> alarm_source_flags[BIT_DIVIDER])
		else $error("masked flag not recorded");

	a_lane_clear: assert property (
		flags_write && !soft_reset_in && reg_req_in.wdata[BIT_LANE_BUF]
		|=> per_lane_buffer_errors_clear_out)
		else $error("per-lane clear pulse missing");

	a_lane_clear_idle: assert property (
		!(flags_write && reg_req_in.wdata[BIT_LANE_BUF]) || soft_reset_in
		|=> !per_lane_buffer_errors_clear_out)
		else $error("per-lane clear pulse without a write");

	a_set_wins: assert property (
		flags_write && !soft_reset_in && set_vec[BIT_SER_LOCK] |=> alarm_source_flags[BIT_SER_LOCK])
		else $error("clear beat a simultaneous alarm");

	c_alarm_pin: cover property (
		cal_status_sel_alarm_in ##1 $rose(calibration_status_pin_out));
	c_clear_all: cover property (
		flags_write && reg_req_in.wdata == 8'h3F ##1 alarm_source_flags == 8'h00);
	c_set_clear_clash: cover property (
		flags_write && (set_vec & reg_req_in.wdata) != 8'h00);

endmodule : alarm_status_aggregator

/* File: alarm_pkg.sv */
// constants, field layout and carrier types of the alarm status aggregator
// assumes a decoded register access port from the serial control port
//
// Operation
// - summary bit is one when any unmasked status bit is set; other bits zero
// - selector routes summary bit onto calibration status pin as interrupt
// - status register resets to 0x3F; writing one clears that bit
// - bit 5 sets on any active lane buffer overflow or underflow
// - bit 4 sets whenever the serializer pll is not locked
// - 8b/10b: bit 3 sets while link enabled but not in data phase
// - 64b/66b: bit 3 sets at link start and on every realignment
// - bit 2 sets whenever sysref realigns the internal clocks
// - bit 0 sets whenever channel ab and cd clock dividers disagree
// - after power-on or software reset all status bits stay one until cleared
// - with link disabled only the clock bit is meaningful
// - mask register resets to 0x3F with masks at bits 5,4,3,2,0
// - a set mask bit hides status from summary; status still recorded
// - writing one to bit 5 also clears the per-lane buffer error register

package alarm_pkg;

	localparam int          REG_ADDR_W     = 12;
	localparam int          REG_DATA_W     = 8;
	localparam int          LANES_DEFAULT  = 8;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] SUMMARY_OFFSET = 12'h2C0;
	localparam logic [11:0] FLAGS_OFFSET   = 12'h2C1;
	localparam logic [11:0] DISABLE_OFFSET = 12'h2C2;

	// ----------------------------------------------------------------
	// reset values and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0]  SUMMARY_RESET  = 8'h00;
	localparam logic [7:0]  FLAGS_RESET    = 8'h3F;
	localparam logic [7:0]  DISABLE_RESET  = 8'h3F;
	localparam logic [7:0]  FLAGS_STORED   = 8'h3F;
	localparam logic [7:0]  ALARM_BITS     = 8'h3D;

	localparam int          BIT_LANE_BUF   = 5;
	localparam int          BIT_SER_LOCK   = 4;
	localparam int          BIT_LINK       = 3;
	localparam int          BIT_REALIGN    = 2;
	localparam int          BIT_DIVIDER    = 0;

	typedef struct packed {
		logic                  rd;
		logic                  wr;
		logic [REG_ADDR_W-1:0] addr;
		logic [REG_DATA_W-1:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic pll_locked;
		logic serial_link_enable;
		logic data_phase_state;
		logic mode_64b66b;
		logic link_realign;
		logic sysref_realign;
		logic divider_mismatch;
	} alarm_src_s;

endpackage : alarm_pkg

/* File: testbench.sv */
// self-checking bench for the alarm status aggregator
// assumes the design holds its own assertions; drives every port from here
`timescale 1ns/10ps

module testbench;
	import alarm_pkg::*;

	logic                  ref_clk;
	logic                  reset;
	logic                  soft_reset;
	reg_req_s              req;
	logic [REG_DATA_W-1:0] rdata;
	alarm_src_s            src;
	logic [7:0]            lane_active;
	logic [7:0]            lane_err;
	logic                  sel_alarm;
	logic                  other;
	logic                  pin;
	logic                  lane_clear;
	int                    bad_count;
	int                    checked;
	int                    bits[5] = '{5, 4, 3, 2, 0};

	alarm_status_aggregator #(.LANES(8)) uut (
		.ref_clk_in                      (ref_clk),
		.reset_in                        (reset),
		.soft_reset_in                   (soft_reset),
		.reg_req_in                      (req),
		.reg_rdata_out                   (rdata),
		.alarm_src_in                    (src),
		.lane_active_in                  (lane_active),
		.lane_fifo_error_in              (lane_err),
		.cal_status_sel_alarm_in         (sel_alarm),
		.cal_status_other_in             (other),
		.calibration_status_pin_out      (pin),
		.per_lane_buffer_errors_clear_out(lane_clear)
	);

	// ----------------------------------------------------------------
	// clock, verdict and watchdog
	// ----------------------------------------------------------------
	initial ref_clk = 1'b0;
	always #4 ref_clk = ~ref_clk;

	task automatic test_done();
		if (bad_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	initial begin
		#100000;
		bad_count++;
		test_done();
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// write; the lane clear pulse must follow a flags write with bit 5 set
	task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge ref_clk);
		req <= '0;
		#1;
		chk("lane clear", {7'h00, (a == FLAGS_OFFSET) && d[5]}, {7'h00, lane_clear});
	endtask : reg_wr

	task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp, input string name);
		@(posedge ref_clk);
		req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		req <= '0;
		#1;
		chk(name, exp, rdata);
	endtask : reg_rd

	// drive the alarm condition on the source behind status bit b on or off; it holds until the next call
	task automatic pulse(input int b, input logic on);
		@(posedge ref_clk);
		case (b)
			5: lane_err[2]        <= on;
			4: src.pll_locked     <= !on;
			3: src.data_phase_state <= !on;
			2: src.sysref_realign <= on;
			default: src.divider_mismatch <= on;
		endcase
	endtask : pulse

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		reset = 1'b1;
		soft_reset = 1'b0;
		req = '0;
		src = '{pll_locked: 1'b1, serial_link_enable: 1'b1, data_phase_state: 1'b1, default: 1'b0};
		lane_active = 8'hFF;
		lane_err = 8'h00;
		sel_alarm = 1'b1;
		other = 1'b0;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		reg_rd(FLAGS_OFFSET, 8'h3F, "flags reset");
		reg_rd(DISABLE_OFFSET, 8'h3F, "mask reset");
		reg_rd(SUMMARY_OFFSET, 8'h00, "summary masked");
		reg_rd(12'h2C3, 8'h00, "unmapped");
		reg_wr(FLAGS_OFFSET, 8'hFF);
		reg_rd(FLAGS_OFFSET, 8'h00, "flags cleared");
		reg_wr(DISABLE_OFFSET, 8'h00);
		reg_rd(DISABLE_OFFSET, 8'h00, "mask written");
		reg_rd(SUMMARY_OFFSET, 8'h00, "summary idle");
		chk("pin idle", 8'h00, {7'h00, pin});
		foreach (bits[i]) begin
			pulse(bits[i], 1'b1);
			pulse(bits[i], 1'b0);
			reg_rd(FLAGS_OFFSET, 8'h01 << bits[i], "source flag");
			reg_rd(SUMMARY_OFFSET, 8'h01, "summary set");
			chk("pin alarm", 8'h01, {7'h00, pin});
			reg_wr(FLAGS_OFFSET, 8'h01 << bits[i]);
			reg_rd(SUMMARY_OFFSET, 8'h00, "summary cleared");
		end
		// inactive lane errors are ignored
		@(posedge ref_clk);
		lane_active <= 8'hFB;
		pulse(5, 1'b1);
		pulse(5, 1'b0);
		reg_rd(FLAGS_OFFSET, 8'h00, "inactive lane");
		reg_wr(DISABLE_OFFSET, 8'h01);
		pulse(0, 1'b1);
		pulse(0, 1'b0);
		reg_rd(FLAGS_OFFSET, 8'h01, "masked flag kept");
		reg_rd(SUMMARY_OFFSET, 8'h00, "summary masked bit");
		reg_wr(DISABLE_OFFSET, 8'h00);
		reg_rd(SUMMARY_OFFSET, 8'h01, "summary unmasked");
		// alarm held through its clear
		pulse(0, 1'b1);
		reg_wr(FLAGS_OFFSET, 8'h01);
		reg_rd(FLAGS_OFFSET, 8'h01, "set beats clear");
		pulse(0, 1'b0);
		reg_wr(FLAGS_OFFSET, 8'h01);
		reg_rd(FLAGS_OFFSET, 8'h00, "clear after release");
		// clock bit still recorded with the link disabled
		@(posedge ref_clk);
		src.serial_link_enable <= 1'b0;
		pulse(0, 1'b1);
		pulse(0, 1'b0);
		reg_rd(FLAGS_OFFSET, 8'h01, "clock bit link off");
		// 64b/66b: link start and realignment
		@(posedge ref_clk);
		src.mode_64b66b <= 1'b1;
		reg_wr(FLAGS_OFFSET, 8'h3F);
		@(posedge ref_clk);
		src.serial_link_enable <= 1'b1;
		reg_rd(FLAGS_OFFSET, 8'h08, "link start");
		reg_wr(FLAGS_OFFSET, 8'h08);
		reg_rd(FLAGS_OFFSET, 8'h00, "link running");
		@(posedge ref_clk);
		src.link_realign <= 1'b1;
		@(posedge ref_clk);
		src.link_realign <= 1'b0;
		reg_rd(FLAGS_OFFSET, 8'h08, "link realign");
		// software reset restores both registers
		@(posedge ref_clk);
		soft_reset <= 1'b1;
		@(posedge ref_clk);
		soft_reset <= 1'b0;
		reg_rd(FLAGS_OFFSET, 8'h3F, "soft flags");
		reg_rd(DISABLE_OFFSET, 8'h3F, "soft mask");
		// hardware reset in mid-run restores both registers
		reg_wr(FLAGS_OFFSET, 8'h3F);
		reg_wr(DISABLE_OFFSET, 8'h00);
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		reg_rd(FLAGS_OFFSET, 8'h3F, "reset flags");
		reg_rd(DISABLE_OFFSET, 8'h3F, "reset mask");
		// pin routed to the other source
		@(posedge ref_clk);
		sel_alarm <= 1'b0;
		other <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("pin other high", 8'h01, {7'h00, pin});
		chk("read data held", 8'h3F, rdata);
		@(posedge ref_clk);
		other <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("pin other low", 8'h00, {7'h00, pin});
		test_done();
	end

endmodule : testbench
